// ==== asf_defs.svh ====
// constants for the alu status flag register
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
`define ASF_FLAG_ADDR 12'hFD8
`define ASF_BIT_NEG 4
`define ASF_BIT_OVF 3
`define ASF_BIT_ZERO 2
`define ASF_BIT_DIG 1
`define ASF_BIT_CARRY 0
`define ASF_IMPL_MASK 8'h1F
`define ASF_RESET_VAL 5'h00
`endif

// ==== asf_pkg.sv ====
// types for the alu status flag register
package asf_pkg;
    typedef enum logic [3:0] {
        ASF_OP_NONE = 4'h0,
        ASF_OP_ADD = 4'h1,
        ASF_OP_SUB = 4'h2,
        ASF_OP_LOGIC = 4'h3,
        ASF_OP_CLEAR = 4'h4,
        ASF_OP_ROT_RIGHT = 4'h5,
        ASF_OP_ROT_LEFT = 4'h6,
        ASF_OP_MOVE = 4'h7,
        ASF_OP_BIT = 4'h8,
        ASF_OP_SWAP = 4'h9,
        ASF_OP_PASS_NZ = 4'hA
    } asf_op_e;
endpackage

// ==== asf_alu_if.sv ====
// flag result bundle between compute unit and register
`timescale 1ns/1ps
`default_nettype none
interface asf_alu_if;
    logic [7:0] result;
    logic [4:0] flags;
    logic [4:0] flag_mask;
    modport calc (output result, output flags, output flag_mask);
    modport reg_side (input result, input flags, input flag_mask);
endinterface
`default_nettype wire

// ==== asf_calc.sv ====
// combinational alu computing result and flag values
`timescale 1ns/1ps
`default_nettype none
`include "asf_defs.svh"
module asf_calc (
    // operation
    input wire asf_pkg::asf_op_e op,
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] opnd_b,
    input wire logic [4:0] cur_flags,
    // result
    asf_alu_if.calc out_if
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b_eff;
    logic cin;
    logic [7:0] res;
    logic [4:0] fl;
    logic [4:0] msk;

    always_comb begin
        b_eff = (op == asf_pkg::ASF_OP_SUB) ? ~opnd_b : opnd_b;
        cin = (op == asf_pkg::ASF_OP_SUB);
        sum = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, cin};
        nib = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        res = opnd_a;
        fl = cur_flags;
        msk = 5'h00;
        unique case (op)
            asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB: begin
                res = sum[7:0];
                fl[`ASF_BIT_CARRY] = sum[8];
                fl[`ASF_BIT_DIG] = nib[4];
                fl[`ASF_BIT_OVF] = (opnd_a[7] == b_eff[7]) && (sum[7] != opnd_a[7]);
                msk = 5'h1F;
            end
            asf_pkg::ASF_OP_LOGIC, asf_pkg::ASF_OP_PASS_NZ: begin
                res = opnd_a;
                msk = 5'h14;
            end
            asf_pkg::ASF_OP_CLEAR: begin
                res = 8'h00;
                msk = 5'h04;
            end
            asf_pkg::ASF_OP_ROT_RIGHT: begin
                res = {cur_flags[`ASF_BIT_CARRY], opnd_a[7:1]};
                fl[`ASF_BIT_CARRY] = opnd_a[0];
                msk = 5'h15;
            end
            asf_pkg::ASF_OP_ROT_LEFT: begin
                res = {opnd_a[6:0], cur_flags[`ASF_BIT_CARRY]};
                fl[`ASF_BIT_CARRY] = opnd_a[7];
                msk = 5'h15;
            end
            asf_pkg::ASF_OP_SWAP: begin
                res = {opnd_a[3:0], opnd_a[7:4]};
            end
            asf_pkg::ASF_OP_MOVE, asf_pkg::ASF_OP_BIT, asf_pkg::ASF_OP_NONE: begin
                res = opnd_a;
            end
            default: begin
                res = opnd_a;
            end
        endcase
        fl[`ASF_BIT_NEG] = res[7];
        fl[`ASF_BIT_ZERO] = (res == 8'h00);
    end

    assign out_if.result = res;
    assign out_if.flags = fl;
    assign out_if.flag_mask = msk;
endmodule
`default_nettype wire

// ==== asf_status.sv ====
// alu status flag register with data-memory access
//
// Notes on behaviour
// - flag-affecting op targeting flags: drop result, update flags only
// - clear op on flag register sets zero, keeps others
// - bit ops, swap and moves alter no flag unless the flag register is their destination
// - flag register usable as operand like any other register
// - bits 7 to 5 read zero; low five read/write, undefined at power-on
// - negative flag copies result msb
// - overflow flag set when signed result leaves seven-bit range
// - zero flag set when result equals zero
// - add/sub: digit flag is carry out of bit three
// - add/sub: carry flag is carry out of bit seven
// - subtraction adds two's complement; carries act as inverted borrows
// - rotates load carry with bit shifted out
`timescale 1ns/1ps
`default_nettype none
`include "asf_defs.svh"
module asf_status #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction execution
    input wire logic exec_en,
    input wire asf_pkg::asf_op_e exec_op,
    input wire logic [7:0] exec_opnd_a,
    input wire logic [7:0] exec_opnd_b,
    input wire logic [ADDR_W-1:0] exec_dest_addr,
    input wire logic exec_dest_file,
    // data memory write path for plain writes
    input wire logic mem_wr_en,
    input wire logic [ADDR_W-1:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    // data memory read path
    input wire logic [ADDR_W-1:0] mem_rd_addr,
    // outputs
    output logic [7:0] exec_result,
    output logic exec_result_wr,
    output logic [7:0] mem_rd_data,
    output logic [4:0] flags_out
);
    // ---------------------------------------------------------------
    // compute
    // ---------------------------------------------------------------
    asf_alu_if alu_if ();
    logic [4:0] flags_r;
    logic [4:0] flags_nxt;
    logic [7:0] res_r;
    logic [7:0] res_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic tgt_flags;

    function automatic logic is_flag_addr(input logic [ADDR_W-1:0] a);
        is_flag_addr = (a == ADDR_W'(`ASF_FLAG_ADDR));
    endfunction

    asf_calc u_calc (
        .op(exec_op),
        .opnd_a(exec_opnd_a),
        .opnd_b(exec_opnd_b),
        .cur_flags(flags_r),
        .out_if(alu_if.calc)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        res_nxt = res_r;
        wr_nxt = 1'b0;
        tgt_flags = exec_dest_file && is_flag_addr(exec_dest_addr);
        rd_nxt = {3'b000, flags_r} & `ASF_IMPL_MASK;
        if (!is_flag_addr(mem_rd_addr)) begin
            rd_nxt = 8'h00;
        end
        if (mem_wr_en && is_flag_addr(mem_wr_addr)) begin
            flags_nxt = mem_wr_data[4:0];
        end
        if (exec_en) begin
            if (tgt_flags && alu_if.flag_mask != 5'h00) begin
                flags_nxt = (flags_r & ~alu_if.flag_mask)
                          | (alu_if.flags & alu_if.flag_mask);
            end else begin
                if (tgt_flags) begin
                    flags_nxt = alu_if.result[4:0];
                end else begin
                    flags_nxt = (flags_nxt & ~alu_if.flag_mask)
                              | (alu_if.flags & alu_if.flag_mask);
                end
                res_nxt = alu_if.result;
                wr_nxt = !tgt_flags;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_r <= `ASF_RESET_VAL;
            res_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 8'h00;
        end else begin
            flags_r <= flags_nxt;
            res_r <= res_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign exec_result = res_r;
    assign exec_result_wr = wr_r;
    assign mem_rd_data = rd_r;
    assign flags_out = flags_r;
endmodule
`default_nettype wire

// ==== asf_status_props.sv ====
// checker for the alu status flag register
`timescale 1ns/1ps
`default_nettype none
module asf_status_props #(parameter int ADDR_W = 12) (
    // core side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic exec_en,
    input wire asf_pkg::asf_op_e exec_op,
    input wire logic [7:0] exec_opnd_a,
    input wire logic [7:0] exec_opnd_b,
    input wire logic [ADDR_W-1:0] exec_dest_addr,
    input wire logic exec_dest_file,
    // results
    input wire logic exec_result_wr,
    input wire logic [4:0] flags_out
);
    wire tf = exec_dest_file && exec_dest_addr == 12'hFD8;
    wire [3:0] op = exec_en ? exec_op : 4'h0;
    wire [8:0] s = exec_opnd_a + exec_opnd_b;
    wire [4:0] h = exec_opnd_a[3:0] + exec_opnd_b[3:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    carry_add_a: assert property (op == 4'h1 |=> flags_out[0] == $past(s[8]))
        else $error("carry");
    digit_add_a: assert property (op == 4'h1 |=> flags_out[1] == $past(h[4]))
        else $error("digit");
    ovf_add_a: assert property (op == 4'h1 |=> flags_out[3] ==
        $past(s[7] != exec_opnd_a[7] && exec_opnd_a[7] == exec_opnd_b[7])) else $error("overflow");
    sign_zero_a: assert property (op == 4'h1 |=> flags_out[4] == $past(s[7]) &&
        flags_out[2] == $past(s[7:0] == 8'h00)) else $error("sign or zero");
    borrow_sub_a: assert property (op == 4'h2 |=>
        flags_out[0] == $past(exec_opnd_a >= exec_opnd_b)) else $error("borrow");
    clear_zero_a: assert property (op == 4'h4 && tf |=>
        flags_out == ($past(flags_out) | 5'h04)) else $error("clear");
    keep_flags_a: assert property (op inside {4'h7, 4'h8, 4'h9} && !tf |=>
        $stable(flags_out)) else $error("flags moved");
    wb_pulse_a: assert property ($past(rst_n) |->
        exec_result_wr == $past(exec_en && !tf)) else $error("write back");
    cover property (op == 4'h1 && tf);
    cover property (op == 4'h6);
    cover property (op == 4'h4 && tf);
endmodule
bind asf_status asf_status_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ==== asf_core.sv ====
// cpu core model issuing one instruction per call
`timescale 1ns/1ps
`default_nettype none
module asf_core (
    // clock
    input wire logic clk_sys,
    // instruction
    output logic exec_en = 1'b0,
    output asf_pkg::asf_op_e exec_op = asf_pkg::ASF_OP_NONE,
    output logic [7:0] exec_opnd_a = 8'h00,
    output logic [7:0] exec_opnd_b = 8'h00,
    output logic [11:0] exec_dest_addr = 12'hFD8,
    output logic exec_dest_file = 1'b0
);
    task automatic go(input logic [3:0] o, input logic [7:0] a, b, input logic f);
        @(posedge clk_sys) #1;
        exec_en = 1'b1;
        exec_op = asf_pkg::asf_op_e'(o);
        exec_opnd_a = a;
        exec_opnd_b = b;
        exec_dest_file = f;
        @(posedge clk_sys) #1;
        exec_en = 1'b0;
        exec_opnd_a = ~a;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// testbench for the alu status flag register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, mem_wr_en = 1'b0;
    logic [11:0] mem_wr_addr = 12'hFD8, mem_rd_addr = 12'hFD8, exec_dest_addr;
    logic [7:0] mem_wr_data = 8'h00, exec_opnd_a, exec_opnd_b, exec_result, mem_rd_data;
    logic exec_en, exec_dest_file, exec_result_wr;
    asf_pkg::asf_op_e exec_op;
    logic [4:0] flags_out;
    int fail_count = 0, n_checks = 0;
    asf_core CORE (.*);
    asf_status DUT (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_arith;
        CORE.go(4'h1, 8'h7F, 8'h01, 1'b0);
        chk("flags", 8'h1A, flags_out);
        chk("result", 8'h80, exec_result);
        CORE.go(4'h1, 8'hFF, 8'h01, 1'b0);
        chk("flags", 8'h07, flags_out);
        CORE.go(4'h2, 8'h05, 8'h06, 1'b0);
        chk("flags", 8'h10, flags_out);
        CORE.go(4'h6, 8'h81, 8'h00, 1'b0);
        chk("carry", 8'h01, flags_out[0]);
        chk("result", 8'h02, exec_result);
        CORE.go(4'h5, 8'h01, 8'h00, 1'b0);
        chk("flags", 8'h11, flags_out);
        chk("result", 8'h80, exec_result);
        CORE.go(4'h3, 8'h00, 8'h00, 1'b0);
        chk("flags", 8'h05, flags_out);
        $display("arith test done");
    endtask
    task automatic t_flags;
        @(posedge clk_sys) #1;
        mem_wr_en = 1'b1;
        mem_wr_data = 8'hFB;
        @(posedge clk_sys) #1;
        mem_wr_en = 1'b0;
        mem_wr_data = 8'h04;
        chk("flags", 8'h1B, flags_out);
        @(posedge clk_sys) #1;
        chk("read", 8'h1B, mem_rd_data);
        CORE.go(4'h4, 8'h00, 8'h00, 1'b1);
        chk("flags", 8'h1F, flags_out);
        CORE.go(4'h1, 8'h01, 8'h01, 1'b1);
        chk("wb", 8'h00, exec_result_wr);
        for (int i = 7; i < 10; i++) CORE.go(4'(i), 8'h00, 8'h00, 1'b0);
        chk("flags", 8'h00, flags_out);
        chk("wb", 8'h01, exec_result_wr);
        CORE.go(4'h9, 8'h30, 8'h00, 1'b1);
        chk("flags", 8'h03, flags_out);
        chk("wb", 8'h00, exec_result_wr);
        $display("flag register test done");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        chk("reset", 8'h00, flags_out);
        t_arith;
        t_flags;
        stop_test;
    end
    initial begin
        #5000;
        fail_count++;
        stop_test;
    end
endmodule
`default_nettype wire
